// [core/pwt_a_timer.v]
// One A-type timer working as a 16-bit or 8-bit pulse width modulator.
`include "pwt_defines.vh"
module pwt_a_timer (
  input wire clk_sys,
  input wire sys_rst,
  input wire run,
  input wire gate,
  input wire mode8,
  input wire trig,
  input wire tick,
  input wire wr,
  input wire [15:0] wdata,
  output reg [15:0] rld_q,
  output reg pulse_q,
  output reg irq_q,
  output reg uf_q
);
  reg active_q;
  reg started_q;
  reg [15:0] hi_q;
  reg [15:0] pd_q;
  reg [7:0] pre_q;
  wire unit;
  wire [15:0] plen;
  wire [15:0] hlen;
  // In 8-bit mode the low byte prescales the count source by m+1.
  assign unit = active_q && tick && (!mode8 || pre_q == 8'h00);
  assign plen = mode8 ? `PWT_PER8 : `PWT_PER16;
  assign hlen = mode8 ? {8'h00, rld_q[15:8]} : rld_q;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      active_q <= 1'b0;
      started_q <= 1'b0;
      hi_q <= 16'h0000;
      pd_q <= 16'h0000;
      pre_q <= 8'h00;
      rld_q <= 16'h0000;
      pulse_q <= 1'b0;
      irq_q <= 1'b0;
      uf_q <= 1'b0;
    end else begin
      irq_q <= 1'b0;
      uf_q <= 1'b0;
      if (wr) begin
        rld_q <= wdata;
      end
      if (!run) begin
        active_q <= 1'b0;
        started_q <= 1'b0;
        pulse_q <= 1'b0;
        // A stop while high is still a falling pulse, so software sees it end.
        irq_q <= pulse_q;
        pd_q <= 16'h0000;
        pre_q <= 8'h00;
      end else if (!active_q) begin
        // Once active, further triggers are simply not looked at.
        if (!gate || trig) begin
          active_q <= 1'b1;
        end
      end
      if (active_q && tick && run) begin
        started_q <= 1'b1;
        if (mode8) begin
          pre_q <= (pre_q == 8'h00) ? rld_q[7:0] : pre_q - 8'h01;
        end
      end
      if (wr && (!run || !started_q)) begin
        hi_q <= mode8 ? {8'h00, wdata[15:8]} : wdata;
      end else if (run && unit) begin
        if (pd_q == 16'h0000) begin
          // Period boundary: rising edge takes the newest reload value.
          pd_q <= plen - 16'h0001;
          hi_q <= hlen;
          pulse_q <= (hlen != 16'h0000);
          uf_q <= 1'b1;
        end else begin
          pd_q <= pd_q - 16'h0001;
          if (hi_q != 16'h0000) begin
            hi_q <= hi_q - 16'h0001;
            if (hi_q == 16'h0001) begin
              pulse_q <= 1'b0;
              irq_q <= pulse_q;
            end
          end
        end
      end
    end
  end
endmodule // pwt_a_timer

// [core/pwt_b_timer.v]
// One B-type down-counter used in timer mode and event counter mode.
`include "pwt_defines.vh"
module pwt_b_timer (
  input wire clk_sys,
  input wire sys_rst,
  input wire run,
  input wire tick,
  input wire wr,
  input wire [15:0] wdata,
  output reg [15:0] cnt_q,
  output reg uf_q
);
  reg [15:0] rld_q;
  reg started_q;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      rld_q <= 16'h0000;
      cnt_q <= 16'h0000;
      started_q <= 1'b0;
      uf_q <= 1'b0;
    end else begin
      uf_q <= 1'b0;
      if (!run) begin
        started_q <= 1'b0;
      end else if (tick) begin
        started_q <= 1'b1;
      end
      if (wr) begin
        rld_q <= wdata;
      end
      if (wr && (!run || !started_q)) begin
        cnt_q <= wdata;
      end else if (run && tick) begin
        if (cnt_q == 16'h0000) begin
          cnt_q <= rld_q;
          uf_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 16'h0001;
        end
      end
    end
  end
endmodule // pwt_b_timer

// [core/pwt_defines.vh]
// Register offsets, field positions and timing constants of the timer block.
`ifndef PWT_DEFINES_VH
`define PWT_DEFINES_VH
`define PWT_OFF_START 8'h00
`define PWT_OFF_USTART 8'h01
`define PWT_OFF_TRGSEL 8'h02
`define PWT_OFF_AMODE 8'h10
`define PWT_OFF_ACNT 8'h18
`define PWT_OFF_BMODE 8'h20
`define PWT_OFF_BCNT 8'h28
`define PWT_B_RUN_LSB 5
`define PWT_B_RUN_MSB 7
`define PWT_AM_GATE 0
`define PWT_AM_8BIT 1
`define PWT_AM_EDGE 2
`define PWT_AM_SRC_LSB 3
`define PWT_AM_SRC_MSB 5
`define PWT_BM_OPM_LSB 0
`define PWT_BM_OPM_MSB 1
`define PWT_BM_EDGE 2
`define PWT_BM_CHAIN 3
`define PWT_BM_SRC_LSB 4
`define PWT_BM_SRC_MSB 6
`define PWT_OPM_TIMER 2'h0
`define PWT_OPM_EVENT 2'h1
`define PWT_TRG_PIN 2'h0
`define PWT_TRG_B2 2'h1
`define PWT_TRG_LOWER 2'h2
`define PWT_TRG_HIGHER 2'h3
`define PWT_SRC_COUNT 3'h5
`define PWT_DIV2_LAST 5'h01
`define PWT_DIV8_LAST 5'h07
`define PWT_DIV32_LAST 5'h1f
`define PWT_PER16 16'hffff
`define PWT_PER8 16'h00ff
`endif

// [core/pwt_top.v]
// Top of the timer block: register port, prescaler, pin synchronisers and timers.
//
// Overview of operation
// - Each A timer is a down-counting 16-bit or 8-bit pulse width modulator.
// - The high counter reloads from the reload register at each rising pulse edge.
// - Triggers arriving after a modulator has started are ignored.
// - 16-bit mode: high for n count periods, period fixed at 65535.
// - 8-bit mode: high n*(m+1), period 255*(m+1) count periods.
// - Run bit starts at once, or on the next trigger when gating is chosen.
// - Triggers: pin edge, B2 underflow, lower or higher A neighbour, wrapping.
// - Interrupt request on each falling pulse edge; pulse drives the output pin.
// - Reading an A count register gives no guaranteed value.
// - Writes while stopped or before first tick load reload and counter.
// - Count source is div1, div2, div8, div32 or the subclock div32.
// - A two-bit mode field selects timer or event mode; measurement values hold the counter still.
// - Timer mode counts down, reloads on underflow, raises a request.
// - B0 to B2 run bits are bits 5 to 7 of the shared start register.
// - B count register reads return the live counter value.
// - Event mode counts selected pin edges, reloads and requests on underflow.
// - Event mode may count the preceding B timer's underflows instead, within groups of three (B0 counts B2, B3 counts B5).
// - Event mode divides by n+1 for n from 0000 to FFFF.
`include "pwt_defines.vh"
module pwt_top #(
  parameter NA = 5,
  parameter NB = 6
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire [7:0] addr,
  input wire [15:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  output reg [15:0] rd_data_q,
  input wire subclock_pin,
  input wire [NA-1:0] a_timer_trigger_pin,
  input wire [NB-1:0] b_timer_input_pin,
  output wire [NA-1:0] a_timer_pulse_pin,
  output wire [NA-1:0] a_irq,
  output wire [NB-1:0] b_irq
);
  reg [7:0] shared_start_register_q;
  reg [2:0] upper_start_register_q;
  reg [2*NA-1:0] trgsel_q;
  reg [8*NA-1:0] amode_q;
  reg [8*NB-1:0] bmode_q;
  reg [4:0] pre_q;
  reg [2:0] sub_sync_q;
  reg [4:0] sub_div_q;
  reg sub_tick_q;
  reg [NA-1:0] atrg_s1_q;
  reg [NA-1:0] atrg_s2_q;
  reg [NA-1:0] atrg_s3_q;
  reg [NB-1:0] bin_s1_q;
  reg [NB-1:0] bin_s2_q;
  reg [NB-1:0] bin_s3_q;
  reg [15:0] rd_d;
  wire [4:0] ticks;
  wire [NA-1:0] a_run;
  wire [NB-1:0] b_run;
  wire [NA-1:0] a_uf;
  wire [NB-1:0] b_uf;
  wire [NA-1:0] a_trig;
  wire [NA-1:0] a_tick;
  wire [NB-1:0] b_tick;
  wire [NA-1:0] a_wr;
  wire [NB-1:0] b_wr;
  wire [16*NA-1:0] a_rld;
  wire [16*NB-1:0] b_cnt;
  wire a_mode_hit;
  wire a_cnt_hit;
  wire b_mode_hit;
  wire b_cnt_hit;
  wire [2:0] idx;
  wire [4:0] div2_last;
  wire [4:0] div8_last;
  integer k;

  assign idx = addr[2:0];
  assign a_mode_hit = (addr[7:3] == `PWT_OFF_AMODE >> 3) && (idx < NA);
  assign a_cnt_hit = (addr[7:3] == `PWT_OFF_ACNT >> 3) && (idx < NA);
  assign b_mode_hit = (addr[7:3] == `PWT_OFF_BMODE >> 3) && (idx < NB);
  assign b_cnt_hit = (addr[7:3] == `PWT_OFF_BCNT >> 3) && (idx < NB);

  // Register writes. Run bits clear on reset so nothing counts until started.
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      shared_start_register_q <= 8'h00;
      upper_start_register_q <= 3'h0;
      trgsel_q <= {2*NA{1'b0}};
      amode_q <= {8*NA{1'b0}};
      bmode_q <= {8*NB{1'b0}};
    end else if (wr_en) begin
      if (addr == `PWT_OFF_START) begin
        shared_start_register_q <= wr_data[7:0];
      end
      if (addr == `PWT_OFF_USTART) begin
        upper_start_register_q <= wr_data[`PWT_B_RUN_MSB:`PWT_B_RUN_LSB];
      end
      if (addr == `PWT_OFF_TRGSEL) begin
        trgsel_q <= wr_data[2*NA-1:0];
      end
      if (a_mode_hit) begin
        amode_q[8*idx +: 8] <= wr_data[7:0];
      end
      if (b_mode_hit) begin
        bmode_q[8*idx +: 8] <= wr_data[7:0];
      end
    end
  end

  // Read path; unmapped addresses read as zero.
  always @* begin
    rd_d = 16'h0000;
    if (addr == `PWT_OFF_START) begin
      rd_d = {8'h00, shared_start_register_q};
    end
    if (addr == `PWT_OFF_USTART) begin
      rd_d = {8'h00, upper_start_register_q, 5'h00};
    end
    if (addr == `PWT_OFF_TRGSEL) begin
      rd_d[2*NA-1:0] = trgsel_q;
    end
    if (a_mode_hit) begin
      rd_d = {8'h00, amode_q[8*idx +: 8]};
    end
    if (a_cnt_hit) begin
      // The live modulator state is not exposed; the reload value is returned.
      rd_d = a_rld[16*idx +: 16];
    end
    if (b_mode_hit) begin
      rd_d = {8'h00, bmode_q[8*idx +: 8]};
    end
    if (b_cnt_hit) begin
      rd_d = b_cnt[16*idx +: 16];
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_data_q <= 16'h0000;
    end else if (rd_en) begin
      rd_data_q <= rd_d;
    end else begin
      rd_data_q <= 16'h0000;
    end
  end

  // Prescaler and subclock divider produce one-cycle count source ticks.
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pre_q <= 5'h00;
      sub_sync_q <= 3'h0;
      sub_div_q <= 5'h00;
      sub_tick_q <= 1'b0;
    end else begin
      pre_q <= pre_q + 5'h01;
      sub_sync_q <= {sub_sync_q[1:0], subclock_pin};
      sub_tick_q <= 1'b0;
      if (sub_sync_q[1] && !sub_sync_q[2]) begin
        sub_div_q <= sub_div_q + 5'h01;
        sub_tick_q <= (sub_div_q == `PWT_DIV32_LAST);
      end
    end
  end
  assign ticks[0] = 1'b1;
  // A literal cannot be bit-selected, so the tick points are held in named wires.
  assign div2_last = `PWT_DIV2_LAST;
  assign div8_last = `PWT_DIV8_LAST;
  assign ticks[1] = (pre_q[0] == div2_last[0]);
  assign ticks[2] = (pre_q[2:0] == div8_last[2:0]);
  assign ticks[3] = (pre_q == `PWT_DIV32_LAST);
  assign ticks[4] = sub_tick_q;

  // Pin inputs pass two flip-flops; the third stage only feeds edge detection.
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      atrg_s1_q <= {NA{1'b0}};
      atrg_s2_q <= {NA{1'b0}};
      atrg_s3_q <= {NA{1'b0}};
      bin_s1_q <= {NB{1'b0}};
      bin_s2_q <= {NB{1'b0}};
      bin_s3_q <= {NB{1'b0}};
    end else begin
      atrg_s1_q <= a_timer_trigger_pin;
      atrg_s2_q <= atrg_s1_q;
      atrg_s3_q <= atrg_s2_q;
      bin_s1_q <= b_timer_input_pin;
      bin_s2_q <= bin_s1_q;
      bin_s3_q <= bin_s2_q;
    end
  end

  assign a_run = shared_start_register_q[NA-1:0];
  assign b_run = {upper_start_register_q,
    shared_start_register_q[`PWT_B_RUN_MSB:`PWT_B_RUN_LSB]};

  genvar i;
  generate
    for (i = 0; i < NA; i = i + 1) begin : g_a
      wire [7:0] md;
      wire [1:0] ts;
      wire [2:0] src;
      wire pin_edge;
      assign md = amode_q[8*i +: 8];
      assign ts = trgsel_q[2*i +: 2];
      assign src = md[`PWT_AM_SRC_MSB:`PWT_AM_SRC_LSB];
      assign pin_edge = md[`PWT_AM_EDGE] ? (atrg_s3_q[i] && !atrg_s2_q[i]) :
        (atrg_s2_q[i] && !atrg_s3_q[i]);
      // Neighbour selection wraps around the ring of A timers.
      assign a_trig[i] = (ts == `PWT_TRG_PIN) ? pin_edge :
        (ts == `PWT_TRG_B2) ? b_uf[2] :
        (ts == `PWT_TRG_LOWER) ? a_uf[(i + NA - 1) % NA] : a_uf[(i + 1) % NA];
      assign a_tick[i] = (src < `PWT_SRC_COUNT) ? ticks[src] : 1'b0;
      assign a_wr[i] = wr_en && a_cnt_hit && (idx == i);
      pwt_a_timer u_a (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .run(a_run[i]),
        .gate(md[`PWT_AM_GATE]),
        .mode8(md[`PWT_AM_8BIT]),
        .trig(a_trig[i]),
        .tick(a_tick[i]),
        .wr(a_wr[i]),
        .wdata(wr_data),
        .rld_q(a_rld[16*i +: 16]),
        .pulse_q(a_timer_pulse_pin[i]),
        .irq_q(a_irq[i]),
        .uf_q(a_uf[i])
      );
    end
    for (i = 0; i < NB; i = i + 1) begin : g_b
      wire [7:0] md;
      wire [1:0] opm;
      wire [2:0] src;
      wire pin_edge;
      wire chain;
      assign md = bmode_q[8*i +: 8];
      assign opm = md[`PWT_BM_OPM_MSB:`PWT_BM_OPM_LSB];
      assign src = md[`PWT_BM_SRC_MSB:`PWT_BM_SRC_LSB];
      assign pin_edge = md[`PWT_BM_EDGE] ? (bin_s3_q[i] && !bin_s2_q[i]) :
        (bin_s2_q[i] && !bin_s3_q[i]);
      // Chains run inside groups of three, so B0 follows B2 and B3 follows B5.
      assign chain = b_uf[(i % 3 == 0) ? i + 2 : i - 1];
      // Measurement mode is not built here: the counter then holds still.
      assign b_tick[i] = (opm == `PWT_OPM_TIMER) ?
        ((src < `PWT_SRC_COUNT) ? ticks[src] : 1'b0) :
        (opm == `PWT_OPM_EVENT) ? (md[`PWT_BM_CHAIN] ? chain : pin_edge) :
        1'b0;
      assign b_wr[i] = wr_en && b_cnt_hit && (idx == i);
      pwt_b_timer u_b (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .run(b_run[i]),
        .tick(b_tick[i]),
        .wr(b_wr[i]),
        .wdata(wr_data),
        .cnt_q(b_cnt[16*i +: 16]),
        .uf_q(b_uf[i])
      );
    end
  endgenerate
  assign b_irq = b_uf;
endmodule // pwt_top

// [tb/pwt_monitor.sv]
// Concurrent checks on the ports of the timer block top.
`include "pwt_defines.vh"
module pwt_monitor #(
  parameter NA = 5,
  parameter NB = 6
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire [7:0] addr,
  input wire [15:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  input wire [15:0] rd_data_q,
  input wire subclock_pin,
  input wire [NA-1:0] a_timer_trigger_pin,
  input wire [NB-1:0] b_timer_input_pin,
  input wire [NA-1:0] a_timer_pulse_pin,
  input wire [NA-1:0] a_irq,
  input wire [NB-1:0] b_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  reg a_run0_q;
  reg b_run0_q;
  reg b_run3_q;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // Shadow run bits, so a stopped timer can be told from a slow one.
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      a_run0_q <= 1'b0;
      b_run0_q <= 1'b0;
      b_run3_q <= 1'b0;
    end else if (wr_en && addr == `PWT_OFF_START) begin
      a_run0_q <= wr_data[0];
      b_run0_q <= wr_data[5];
    end else if (wr_en && addr == `PWT_OFF_USTART) begin
      b_run3_q <= wr_data[5];
    end
  end
  a_read_quiet: assert property (!$past(rd_en) |-> rd_data_q == 16'h0000)
    else $error("read data not zero outside a read answer");
  a_read_once: assert property (rd_en ##1 !rd_en |=> rd_data_q == 16'h0000)
    else $error("read data held longer than one cycle");
  a_irq_single: assert property ((a_irq & $past(a_irq)) == '0)
    else $error("pulse interrupt longer than one cycle");
  a_irq_on_fall: assert property (a_irq == (~a_timer_pulse_pin & $past(a_timer_pulse_pin)))
    else $error("pulse interrupt not tied to falling pulse");
  a_reset_quiet: assert property ($fell(sys_rst) |-> (a_timer_pulse_pin | a_irq) == '0 && b_irq == '0)
    else $error("outputs active right after reset");
  a_stop_low: assert property (!a_run0_q [*3] |-> !a_timer_pulse_pin[0])
    else $error("stopped modulator drives its pin high");
  a_b0_stopped: assert property (!b_run0_q [*3] |-> !b_irq[0])
    else $error("stopped timer B0 raised a request");
  a_b3_stopped: assert property (!b_run3_q [*3] |-> !b_irq[3])
    else $error("stopped timer B3 raised a request");
  cover property (a_irq[0]);
  cover property (b_irq[0]);
  cover property (b_irq[3]);
endmodule // pwt_monitor

bind pwt_top pwt_monitor #(.NA(NA), .NB(NB)) u_mon (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q),
  .subclock_pin(subclock_pin), .a_timer_trigger_pin(a_timer_trigger_pin),
  .b_timer_input_pin(b_timer_input_pin), .a_timer_pulse_pin(a_timer_pulse_pin),
  .a_irq(a_irq), .b_irq(b_irq));

// [tb/tb_top.sv]
// Self-checking testbench for the timer block.
`include "pwt_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 20000;
  logic clk_sys;
  logic sys_rst;
  logic [7:0] addr;
  logic [15:0] wr_data;
  logic wr_en;
  logic rd_en;
  logic subclock_pin;
  logic [4:0] trig;
  logic [5:0] ev;
  wire [15:0] rd_data_q;
  wire [4:0] pin;
  wire [4:0] a_irq;
  wire [5:0] b_irq;
  int fail_count;
  int check_count;
  int cyc;
  pwt_top u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q), .subclock_pin(subclock_pin),
    .a_timer_trigger_pin(trig), .b_timer_input_pin(ev), .a_timer_pulse_pin(pin),
    .a_irq(a_irq), .b_irq(b_irq));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // The subclock runs free at 8 system cycles a period, so its divide-by-32 tick is 256 cycles.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc[1:0] == 2'h3) begin
      subclock_pin <= ~subclock_pin;
    end
    if (cyc == LIMIT) begin
      fail_count++;
      $display("Error at %0t: run did not finish in time", $time);
      end_sim();
    end
  end
  task automatic end_sim;
    $display("Checks %0d, errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  // A gap cycle follows each write so that no strobe is assigned twice in one step.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string what);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    cmp(rd_data_q, exp, what);
    @(posedge clk_sys);
  endtask
  // Counts only cycles sampled high, and returns on the first low one.
  task automatic high_len(input int i, output int w);
    w = 0;
    while (pin[i] !== 1'b0) @(posedge clk_sys);
    while (pin[i] !== 1'b1) @(posedge clk_sys);
    while (pin[i] === 1'b1) begin
      w++;
      @(posedge clk_sys);
    end
    cmp(a_irq[i], 1'b1, "request at pulse fall");
  endtask
  task automatic low_len(input int i, output int w);
    w = 0;
    while (pin[i] === 1'b0) begin
      w++;
      @(posedge clk_sys);
    end
  endtask
  task automatic b_gap(input int i, output int g);
    while (b_irq[i] !== 1'b1) @(posedge clk_sys);
    @(posedge clk_sys);
    g = 1;
    while (b_irq[i] !== 1'b1) begin
      g++;
      @(posedge clk_sys);
    end
  endtask
  task automatic t_reset;
    cmp({pin, a_irq, b_irq}, 16'h0000, "outputs after reset");
    rd_chk(8'h7f, 16'h0000, "unmapped read");
  endtask
  task automatic t_sources;
    int w;
    int div [5] = '{1, 2, 8, 32, 256};
    for (int s = 0; s < 5; s++) begin
      wr(`PWT_OFF_AMODE, 16'(s) << 3);
      wr(`PWT_OFF_ACNT, 16'h0002);
      wr(`PWT_OFF_START, 16'h0001);
      high_len(0, w);
      cmp(w, 2 * div[s], "high time per source");
      wr(`PWT_OFF_START, 16'h0000);
    end
  endtask
  task automatic t_pwm8;
    int w;
    wr(`PWT_OFF_AMODE, 16'h0002);
    wr(`PWT_OFF_ACNT, 16'h0301);
    wr(`PWT_OFF_START, 16'h0001);
    high_len(0, w);
    cmp(w, 6, "8-bit high time");
    low_len(0, w);
    cmp(w, 504, "8-bit low time");
    wr(`PWT_OFF_ACNT, 16'h0501);
    high_len(0, w);
    cmp(w, 10, "reload reaches counter at next rise");
    wr(`PWT_OFF_START, 16'h0000);
  endtask
  task automatic t_gate;
    int w;
    wr(`PWT_OFF_TRGSEL, 16'h0000);
    wr(`PWT_OFF_AMODE + 8'h01, 16'h0003);
    wr(`PWT_OFF_ACNT + 8'h01, 16'h0200);
    wr(`PWT_OFF_START, 16'h0002);
    repeat (20) @(posedge clk_sys);
    cmp(pin[1], 1'b0, "gated timer waits for trigger");
    trig[1] <= 1'b1;
    high_len(1, w);
    cmp(w, 2, "high time after trigger");
    trig[1] <= 1'b0;
    @(posedge clk_sys);
    trig[1] <= 1'b1;
    low_len(1, w);
    // One low cycle went by before the count began.
    cmp(w, 252, "retrigger leaves period alone");
    wr(`PWT_OFF_START, 16'h0000);
    trig[1] <= 1'b0;
  endtask
  task automatic t_btimer;
    int g;
    wr(`PWT_OFF_BMODE, 16'h0000);
    wr(`PWT_OFF_BCNT, 16'h1234);
    rd_chk(`PWT_OFF_BCNT, 16'h1234, "count loaded while stopped");
    wr(`PWT_OFF_BCNT, 16'h0003);
    wr(`PWT_OFF_START, 16'h0020);
    b_gap(0, g);
    cmp(g, 4, "timer mode divides by n+1");
    wr(`PWT_OFF_BMODE + 8'h03, 16'h0000);
    wr(`PWT_OFF_BCNT + 8'h03, 16'h0001);
    wr(`PWT_OFF_USTART, 16'h0020);
    b_gap(3, g);
    cmp(g, 2, "upper start bit runs B3");
    wr(`PWT_OFF_START, 16'h0000);
    wr(`PWT_OFF_USTART, 16'h0000);
  endtask
  task automatic t_event;
    int n;
    n = 0;
    wr(`PWT_OFF_BMODE + 8'h01, 16'h0001);
    wr(`PWT_OFF_BCNT + 8'h01, 16'h0001);
    wr(`PWT_OFF_START, 16'h0040);
    for (int k = 0; k < 24; k++) begin
      ev[1] <= k[1] && k < 16;
      n += (b_irq[1] === 1'b1);
      @(posedge clk_sys);
    end
    cmp(n, 2, "four edges give two underflows");
    wr(`PWT_OFF_BMODE + 8'h02, 16'h0000);
    wr(`PWT_OFF_BCNT + 8'h02, 16'h0001);
    wr(`PWT_OFF_BMODE, 16'h0009);
    wr(`PWT_OFF_BCNT, 16'h0000);
    wr(`PWT_OFF_START, 16'h00a0);
    b_gap(0, n);
    cmp(n, 2, "B0 counts B2 underflows");
    wr(`PWT_OFF_START, 16'h0000);
  endtask
  initial begin
    sys_rst = 1'b1;
    addr = 8'h00;
    wr_data = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    subclock_pin = 1'b0;
    trig = 5'h00;
    ev = 6'h00;
    fail_count = 0;
    check_count = 0;
    cyc = 0;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_sources();
    t_pwm8();
    t_gate();
    t_btimer();
    t_event();
    end_sim();
  end
endmodule // tb_top
